// [dv/rpc_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module rpc_top_sva
   import rpc_pkg::*;
#(
   parameter int NCH = NUM_CH
) (
   // Clock, reset and enable.
   input wire logic               clock_i,
   input wire logic               rst_i,
   input wire logic               ce_i,
   // APB.
   input wire logic               psel_i,
   input wire logic               penable_i,
   input wire logic               pwrite_i,
   input wire logic [PADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0]  pwdata_i,
   input wire logic [DATA_W-1:0]  prdata_o,
   input wire logic               pready_o,
   input wire logic               pslverr_o,
   // Run state and interrupt.
   input wire logic               user_run_i,
   input wire logic               irq_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);

   logic [8:0]         en_q;
   logic [3:0]         hi_q;
   logic [3:0]         lo_q;
   logic               hold_q;
   logic [PADDR_W-1:0] ha_q;
   logic [DATA_W-1:0]  hd_q;
   wire logic done    = psel_i & penable_i & pready_o;
   wire logic rd_done = done & ~pwrite_i;
   wire logic align   = paddr_i[1:0] == 2'b00;
   wire logic chan    = paddr_i[11:8] == CH_REGION;
   wire logic mapped  = (paddr_i < 12'h018) | (chan & (32'(paddr_i[7:5]) < NCH));

   // A read is only held as reference once the run has long stopped, so late updates cannot trip it.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         en_q   <= '0;
         hi_q   <= '0;
         lo_q   <= '0;
         hold_q <= 1'b0;
         ha_q   <= '0;
         hd_q   <= '0;
      end else begin
         hi_q <= !user_run_i ? 4'h0 : (&hi_q ? hi_q : hi_q + 4'h1);
         lo_q <= user_run_i ? 4'h0 : (&lo_q ? lo_q : lo_q + 4'h1);
         if (done && pwrite_i && paddr_i == REG_IRQ_EN) en_q <= pwdata_i[8:0];
         if (user_run_i || (done && pwrite_i)) hold_q <= 1'b0;
         else if (rd_done && chan && lo_q > 4'h5) begin
            hold_q <= 1'b1;
            ha_q   <= paddr_i;
            hd_q   <= prdata_o;
         end
      end
   end

   sequence apb_done_s;
      psel_i && penable_i && pready_o;
   endsequence
   sequence rd_setup_s;
      psel_i && !penable_i && !pwrite_i && ce_i ##1 psel_i && penable_i && ce_i;
   endsequence

   ready_ce_a: assert property (!ce_i |-> !pready_o)
      else $error("pready high with clock enable low");
   write_ready_a: assert property (psel_i && penable_i && pwrite_i && ce_i |-> pready_o)
      else $error("write not answered at once");
   read_wait_a: assert property (rd_setup_s |-> pready_o)
      else $error("read not answered in first access cycle");
   unmapped_err_a: assert property (apb_done_s ##0 (align && !mapped) |->
      pslverr_o && (pwrite_i || prdata_o == ZERO_WORD)) else $error("unmapped access accepted");
   mapped_ok_a: assert property (apb_done_s ##0 (align && mapped) |-> !pslverr_o)
      else $error("mapped access refused");
   cmd_zero_a: assert property (rd_done && paddr_i == REG_CMD |-> prdata_o == ZERO_WORD)
      else $error("command register read not zero");
   frozen_read_a: assert property (rd_done && hold_q && paddr_i == ha_q && lo_q > 4'h5
      |-> prdata_o == hd_q) else $error("result changed while stopped");
   irq_enable_a: assert property (en_q == 9'h000 |-> !irq_o)
      else $error("interrupt with all sources disabled");
   status_run_a: assert property (rd_done && paddr_i == REG_STATUS && (hi_q > 4'h5 || lo_q > 4'h5)
      |-> prdata_o[0] == (hi_q > 4'h5)) else $error("running flag wrong");
endmodule : rpc_top_sva

bind rpc_top rpc_top_sva #(.NCH(NCH)) rpc_top_sva_i (.clock_i, .rst_i, .ce_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .user_run_i, .irq_o);
`default_nettype wire

// [dv/rpc_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
module rpc_top_test
   import rpc_pkg::*;
;
   localparam logic [ADDR_W-1:0] A0 = 32'h0000_0100, A1 = 32'h0000_01FF, B0 = 32'h0000_0200;
   localparam logic [ADDR_W-1:0] B1 = 32'h0000_02FF, C0 = 32'h0000_0300, C1 = 32'h0000_030F;
   localparam logic [ADDR_W-1:0] D0 = 32'h0000_0800, D1 = 32'h0000_080F;
   logic               clock_i;
   logic               rst_i;
   logic               ce_i;
   logic               psel_i    = 1'b0;
   logic               penable_i = 1'b0;
   logic               pwrite_i  = 1'b0;
   logic [PADDR_W-1:0] paddr_i   = '0;
   logic [DATA_W-1:0]  pwdata_i  = '0;
   logic [DATA_W-1:0]  prdata_o, rd;
   logic               pready_o, pslverr_o, irq_o, user_run_i, tgt_clk_i;
   rpc_bus_t           bus_i;
   rpc_pc_t            pc_i;
   int                 fails = 0, checks_done = 0, cyc = 0;

   rpc_top rpc_top_i (.clock_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .bus_i, .pc_i, .user_run_i, .tgt_clk_i, .irq_o);
   rpc_trace_model rpc_trace_model_i (.clock_i(clock_i), .bus_o(bus_i), .pc_o(pc_i),
      .run_o(user_run_i), .tclk_o(tgt_clk_i));

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   // The whole run needs a few hundred cycles; the ceiling leaves ample margin.
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run

   task automatic check(input logic [DATA_W-1:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic rdc(input logic [PADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      apb(1'b0, a, '0);
      check(rd, exp);
   endtask : rdc

   task automatic win(input logic [PADDR_W-1:0] a, input int lo, hi);
      apb(1'b0, a, '0);
      check(32'(rd >= lo && rd <= hi), 32'h0000_0001);
   endtask : win

   function automatic logic [PADDR_W-1:0] ca(input logic [2:0] c, input logic [4:0] o);
      return {CH_REGION, c, o};
   endfunction : ca

   task automatic cfg(input logic [2:0] c, input logic [DATA_W-1:0] ctl,
                      input logic [ADDR_W-1:0] al, ah, bl, bh);
      apb(1'b1, ca(c, CH_A_LO), al);
      apb(1'b1, ca(c, CH_A_HI), ah);
      apb(1'b1, ca(c, CH_B_LO), bl);
      apb(1'b1, ca(c, CH_B_HI), bh);
      apb(1'b1, ca(c, CH_CTRL), ctl);
   endtask : cfg

   task automatic t_reset();
      rdc(REG_GCFG, 32'h0000_0001);
      rdc(REG_CMD, 32'h0000_0000);
      rdc(ca(3'd7, CH_CTRL), 32'h0000_0000);
      rdc(12'h0FC, 32'h0000_0000);
      ce_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      ce_i <= 1'b1;
      rdc(REG_STATUS, 32'h0000_0000);
      apb(1'b1, REG_IRQ_EN, 32'h0000_01FF);
      rdc(REG_IRQ_EN, 32'h0000_01FF);
   endtask : t_reset

   task automatic t_ranges();
      logic [ADDR_W-1:0] tr [8];
      tr = '{A0, A1, C0, 32'h0000_0150, B0, A1, B1, C0};
      apb(1'b1, REG_GCFG, 32'h0000_0005);
      cfg(3'd0, 32'h0000_0002, A0, A1, B0, B1);
      cfg(3'd1, 32'h0000_0001, A0, A1, B0, B1);
      cfg(3'd2, 32'h0000_0004, A0, A1, C0, C1);
      rpc_trace_model_i.run(1'b1);
      apb(1'b0, REG_STATUS, '0);
      check(rd & 32'h0000_0001, 32'h0000_0001);
      foreach (tr[i]) rpc_trace_model_i.exec(tr[i]);
      rpc_trace_model_i.run(1'b0);
      win(ca(3'd0, CH_TIME_LO), 36, 44);
      rdc(ca(3'd0, CH_TIME_HI), 32'h0000_0000);
      rdc(ca(3'd0, CH_COUNT), 32'h0000_0002);
      rdc(ca(3'd0, CH_COUNT), 32'h0000_0002);
      win(ca(3'd1, CH_TIME_LO), 28, 36);
      rdc(ca(3'd1, CH_COUNT), 32'h0000_0002);
      rdc(ca(3'd2, CH_COUNT), 32'h0000_0001);
      check(32'(irq_o), 32'h0000_0001);
      rdc(REG_IRQ_STAT, 32'h0000_0100);
      apb(1'b1, REG_IRQ_EN, 32'h0000_0000);
      @(posedge clock_i);
      check(32'(irq_o), 32'h0000_0000);
      apb(1'b1, REG_IRQ_CLR, 32'h0000_01FF);
      rdc(REG_IRQ_STAT, 32'h0000_0000);
   endtask : t_ranges

   task automatic t_restart_clear();
      rpc_trace_model_i.run(1'b1);
      rpc_trace_model_i.run(1'b0);
      rdc(ca(3'd0, CH_COUNT), 32'h0000_0000);
      rdc(ca(3'd0, CH_CTRL), 32'h0000_0002);
      apb(1'b1, REG_CMD, 32'h0000_0200);
      rdc(ca(3'd1, CH_CTRL), 32'h0000_0000);
      rdc(ca(3'd0, CH_CTRL), 32'h0000_0002);
      apb(1'b1, REG_CMD, 32'h0000_0001);
      rdc(ca(3'd0, CH_CTRL), 32'h0000_0000);
      rdc(ca(3'd2, CH_CTRL), 32'h0000_0000);
   endtask : t_restart_clear

   task automatic t_access();
      int exp [5] = '{3, 1, 1, 0, 1};
      apb(1'b1, REG_GCFG, 32'h0000_0000);
      for (int k = 0; k < 5; k++) cfg(3'(3 + k), 32'(16 * k + 3), A0, A1, D0, D1);
      rpc_trace_model_i.run(1'b1);
      rpc_trace_model_i.access(CYC_PREFETCH, A0);
      rpc_trace_model_i.access(CYC_DMA, D0);
      rpc_trace_model_i.access(CYC_REFRESH, D0);
      rpc_trace_model_i.access(CYC_DATA, D1);
      rpc_trace_model_i.access(CYC_DATA, 32'h0000_0810);
      rpc_trace_model_i.access(CYC_PREFETCH, 32'h0000_0900);
      rpc_trace_model_i.access(CYC_DATA, D0);
      rpc_trace_model_i.run(1'b0);
      for (int k = 0; k < 5; k++) rdc(ca(3'(3 + k), CH_COUNT), 32'(exp[k]));
   endtask : t_access

   task automatic t_target();
      apb(1'b1, REG_GCFG, 32'h0000_0007);
      cfg(3'd0, 32'h0000_0002, A0, A1, B0, B1);
      rpc_trace_model_i.run(1'b1);
      rpc_trace_model_i.exec(A0);
      repeat (5) rpc_trace_model_i.tpulse();
      repeat (4) @(posedge clock_i);
      rpc_trace_model_i.exec(B0);
      rpc_trace_model_i.run(1'b0);
      rdc(ca(3'd0, CH_TIME_LO), 32'h0000_0005);
      rdc(ca(3'd0, CH_TIME_HI), 32'h0000_0000);
   endtask : t_target

   initial begin
      rst_i <= 1'b1;
      ce_i  <= 1'b1;
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset();
      t_ranges();
      t_restart_clear();
      t_access();
      t_target();
      complete_run();
   end
endmodule : rpc_top_test
`default_nettype wire

// [dv/rpc_trace_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rpc_trace_model
   import rpc_pkg::*;
(
   // Clock.
   input  wire logic clock_i,
   // Trace towards the block.
   output rpc_bus_t  bus_o,
   output rpc_pc_t   pc_o,
   output logic      run_o,
   output logic      tclk_o
);
   initial begin
      bus_o  = '0;
      pc_o   = '0;
      run_o  = 1'b0;
      tclk_o = 1'b0;
   end

   // A released address shows its inverse so a stale value can never match by luck.
   task automatic exec(input logic [ADDR_W-1:0] a);
      pc_o <= {1'b1, a};
      repeat (3) @(posedge clock_i);
      pc_o <= {1'b0, ~a};
      @(posedge clock_i);
   endtask : exec

   task automatic access(input rpc_cyc_t k, input logic [ADDR_W-1:0] a);
      bus_o <= {1'b1, k, a};
      repeat (3) @(posedge clock_i);
      bus_o <= {1'b0, k, ~a};
      @(posedge clock_i);
   endtask : access

   // Eight clocks a period keeps the target clock well below a quarter of ours.
   task automatic tpulse();
      tclk_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      tclk_o <= 1'b0;
      repeat (4) @(posedge clock_i);
   endtask : tpulse

   task automatic run(input logic v);
      run_o <= v;
      repeat (4) @(posedge clock_i);
   endtask : run
endmodule : rpc_trace_model
`default_nettype wire

// [hw/rpc_pkg.sv]
`default_nettype none
package rpc_pkg;
   // Geometry.
   localparam int ADDR_W = 32;
   localparam int TIME_W = 40;
   localparam int CNT_W  = 32;
   localparam int NUM_CH = 8;
   localparam int DATA_W = 32;
   localparam int PADDR_W = 12;

   // Timing: system clock and the three internal resolutions, in ns.
   localparam int CLK_PERIOD_NS = 40;
   localparam int RES_160_NS    = 160;
   localparam int RES_40_NS     = 40;
   localparam int RES_20_NS     = 20;
   localparam int DIV_160       = RES_160_NS / CLK_PERIOD_NS;
   localparam int STEP_40       = CLK_PERIOD_NS / RES_40_NS;
   localparam int STEP_20       = CLK_PERIOD_NS / RES_20_NS;
   localparam int STEP_W        = 2;

   typedef enum logic [1:0] {RES_160, RES_40, RES_20, RES_TARGET} rpc_res_t;
   typedef enum logic [2:0] {
      MODE_OFF, MODE_RANGE_TIME, MODE_START_END, MODE_ACCESS, MODE_CALLED
   } rpc_mode_t;
   typedef enum logic [2:0] {ACC_ANY, ACC_DMA, ACC_REFRESH, ACC_PREFETCH, ACC_DATA} rpc_acc_t;
   typedef enum logic [1:0] {CYC_DMA, CYC_REFRESH, CYC_PREFETCH, CYC_DATA} rpc_cyc_t;

   // Observed target bus cycle and executed program counter.
   typedef struct packed {
      logic              vld;
      rpc_cyc_t          kind;
      logic [ADDR_W-1:0] addr;
   } rpc_bus_t;

   typedef struct packed {
      logic              vld;
      logic [ADDR_W-1:0] pc;
   } rpc_pc_t;

   // Global register byte offsets.
   localparam logic [PADDR_W-1:0] REG_GCFG     = 12'h000;
   localparam logic [PADDR_W-1:0] REG_CMD      = 12'h004;
   localparam logic [PADDR_W-1:0] REG_STATUS   = 12'h008;
   localparam logic [PADDR_W-1:0] REG_IRQ_STAT = 12'h00C;
   localparam logic [PADDR_W-1:0] REG_IRQ_EN   = 12'h010;
   localparam logic [PADDR_W-1:0] REG_IRQ_CLR  = 12'h014;

   // Channel window: paddr[11:8] selects it, paddr[7:5] the channel, paddr[4:0] the word.
   localparam logic [3:0] CH_REGION  = 4'h1;
   localparam logic [4:0] CH_CTRL    = 5'h00;
   localparam logic [4:0] CH_A_LO    = 5'h04;
   localparam logic [4:0] CH_A_HI    = 5'h08;
   localparam logic [4:0] CH_B_LO    = 5'h0C;
   localparam logic [4:0] CH_B_HI    = 5'h10;
   localparam logic [4:0] CH_TIME_LO = 5'h14;
   localparam logic [4:0] CH_TIME_HI = 5'h18;
   localparam logic [4:0] CH_COUNT   = 5'h1C;

   // Field positions.
   localparam int GCFG_DET_PC_BIT = 0;
   localparam int GCFG_RES_LSB    = 1;
   localparam int CTRL_MODE_LSB   = 0;
   localparam int CTRL_ACC_LSB    = 4;
   localparam int CMD_ALL_BIT     = 0;
   localparam int CMD_CH_LSB      = 8;
   localparam int TIME_OVF_BIT    = 31;
   localparam int TIME_HI_PAD     = DATA_W - 1 - (TIME_W - DATA_W);
   localparam int STAT_CH_LSB     = 8;
   localparam int IRQ_STOP_BIT    = 8;
   localparam int IRQ_W           = NUM_CH + 1;

   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

   // Inclusive range test.
   function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] lo,
                                     input logic [ADDR_W-1:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction : in_range

   // Bus cycle kind qualification for access counting.
   function automatic logic acc_match(input rpc_acc_t sel, input rpc_cyc_t kind);
      unique case (sel)
         ACC_ANY:      return 1'b1;
         ACC_DMA:      return kind == CYC_DMA;
         ACC_REFRESH:  return kind == CYC_REFRESH;
         ACC_PREFETCH: return kind == CYC_PREFETCH;
         ACC_DATA:     return kind == CYC_DATA;
         default:      return 1'b0;
      endcase
   endfunction : acc_match
endpackage : rpc_pkg
`default_nettype wire

// [hw/rpc_timebase.sv]
`timescale 1ns/1ps
`default_nettype none
module rpc_timebase
   import rpc_pkg::*;
#(
   parameter int DIV = DIV_160
) (
   // Clock and reset.
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // Resolution select and raw target clock pin.
   input  wire rpc_res_t          res_i,
   input  wire logic              tgt_clk_i,
   // Amount the timers advance this cycle.
   output logic [STEP_W-1:0]      step_o
);
   localparam int DIV_W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

   logic [DIV_W-1:0] div_q;
   logic             tgt_s1_q;
   logic             tgt_s2_q;
   logic             tgt_s3_q;
   wire              tick_160 = (div_q == DIV_LAST);
   // The target clock is oversampled, so it must stay below a quarter of clock_i.
   wire              tgt_edge = tgt_s2_q & ~tgt_s3_q;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         div_q    <= '0;
         tgt_s1_q <= 1'b0;
         tgt_s2_q <= 1'b0;
         tgt_s3_q <= 1'b0;
      end else if (ce_i) begin
         div_q    <= tick_160 ? '0 : div_q + DIV_W'(1);
         tgt_s1_q <= tgt_clk_i;
         tgt_s2_q <= tgt_s1_q;
         tgt_s3_q <= tgt_s2_q;
      end
   end

   // The 20 ns grain is finer than the clock, so it advances by two each cycle.
   assign step_o = (res_i == RES_160)    ? {1'b0, tick_160} :
                   (res_i == RES_40)     ? STEP_W'(STEP_40) :
                   (res_i == RES_20)     ? STEP_W'(STEP_20) :
                                           {1'b0, tgt_edge};
endmodule : rpc_timebase
`default_nettype wire

// [hw/rpc_top.sv]
//
// Behaviour
// - Start-to-end mode: start timing in start range, stop in end range.
// - Start-to-end mode: count each pass into the end range.
// - Access mode: count accesses to access range made from code range.
// - Access mode: qualify accesses by any, DMA, refresh, prefetch or data cycle.
// - Called mode: count entries into subroutine range from the caller range.
// - Code ranges are matched against prefetch addresses or executed PC values; access ranges against bus cycle addresses.
// - Timer resolution is 160 ns, 40 ns, 20 ns or the target clock.
// - Execution time counter is 40 bits wide.
// - Counter wrap records overflow, reported instead of the measured time.
// - Target clock source advances timer once per rising input edge; ten hex digits.
// - Start of user execution clears results and starts measuring.
// - Stop of user execution freezes results for readout.
// - One channel or all channels can have their condition cleared.
// - Eight channels share one detection method and one resolution.
// - Single-range mode times only while prefetches lie inside the range.
// - Single-range mode counts a prefetch at the range end address.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rpc_top
   import rpc_pkg::*;
#(
   parameter int NCH = NUM_CH
) (
   // Clock, reset and clock enable.
   input  wire logic                clock_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   // APB slave.
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [PADDR_W-1:0]  paddr_i,
   input  wire logic [DATA_W-1:0]   pwdata_i,
   output logic      [DATA_W-1:0]   prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   // Target processor trace.
   input  wire rpc_bus_t            bus_i,
   input  wire rpc_pc_t             pc_i,
   input  wire logic                user_run_i,
   input  wire logic                tgt_clk_i,
   // Interrupt.
   output logic                     irq_o
);
   // Trace synchronisers. The trace is assumed to hold each cycle for at least
   // three clocks, so the bus fields settle together before they are used.
   rpc_bus_t bus_s1_q, bus_q;
   rpc_pc_t  pc_s1_q, pc_q;
   logic     run_s1_q, run_q, run_d1_q;
   logic     bus_v_q, pc_v_q;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         bus_s1_q <= '0;
         bus_q    <= '0;
         pc_s1_q  <= '0;
         pc_q     <= '0;
         run_s1_q <= 1'b0;
         run_q    <= 1'b0;
         run_d1_q <= 1'b0;
         bus_v_q  <= 1'b0;
         pc_v_q   <= 1'b0;
      end else if (ce_i) begin
         bus_s1_q <= bus_i;
         bus_q    <= bus_s1_q;
         pc_s1_q  <= pc_i;
         pc_q     <= pc_s1_q;
         run_s1_q <= user_run_i;
         run_q    <= run_s1_q;
         run_d1_q <= run_q;
         bus_v_q  <= bus_q.vld;
         pc_v_q   <= pc_q.vld;
      end
   end

   wire run_start = run_q & ~run_d1_q;
   wire run_stop  = ~run_q & run_d1_q;

   // Global configuration shared by all channels.
   logic     det_pc_q;
   rpc_res_t res_q;
   logic [IRQ_W-1:0] irq_stat_q, irq_en_q;

   // Executed-address event from the chosen detection method.
   wire              exec_vld  = det_pc_q ? pc_q.vld
                                          : (bus_q.vld && bus_q.kind == CYC_PREFETCH);
   wire [ADDR_W-1:0] exec_addr = det_pc_q ? pc_q.pc : bus_q.addr;
   // Trace cycles span clocks, so counts use their first clock.
   wire              bus_new   = bus_q.vld & ~bus_v_q;
   wire              exec_new  = det_pc_q ? pc_q.vld & ~pc_v_q
                                          : bus_new && bus_q.kind == CYC_PREFETCH;

   logic [STEP_W-1:0] step;

   rpc_timebase #(
      .DIV        (DIV_160)
   ) u_timebase (
      .clock_i    (clock_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .res_i      (res_q),
      .tgt_clk_i  (tgt_clk_i),
      .step_o     (step)
   );

   // APB decode.
   wire       wr_en    = psel_i & penable_i & pwrite_i & pready_o;
   wire       ch_sel   = (paddr_i[11:8] == CH_REGION) && (32'(paddr_i[7:5]) < NCH);
   wire [2:0] ch_idx   = paddr_i[7:5];
   wire [4:0] ch_word  = paddr_i[4:0];
   wire       glob_hit = (paddr_i == REG_GCFG) || (paddr_i == REG_CMD) ||
                         (paddr_i == REG_STATUS) || (paddr_i == REG_IRQ_STAT) ||
                         (paddr_i == REG_IRQ_EN) || (paddr_i == REG_IRQ_CLR);
   wire       hit      = glob_hit || (ch_sel && (ch_word[1:0] == 2'b00));
   wire       cmd_wr   = wr_en && (paddr_i == REG_CMD);
   wire       clr_all  = cmd_wr && pwdata_i[CMD_ALL_BIT];
   wire [NCH-1:0] clr_mask = cmd_wr ? pwdata_i[CMD_CH_LSB +: NCH] : '0;

   // Per-channel storage.
   rpc_mode_t         mode_q   [NCH];
   rpc_acc_t          acc_q    [NCH];
   logic [ADDR_W-1:0] a_lo_q   [NCH];
   logic [ADDR_W-1:0] a_hi_q   [NCH];
   logic [ADDR_W-1:0] b_lo_q   [NCH];
   logic [ADDR_W-1:0] b_hi_q   [NCH];
   logic [TIME_W-1:0] time_q   [NCH];
   logic [CNT_W-1:0]  cnt_q    [NCH];
   logic [NCH-1:0]    ovf_q;
   logic [NCH-1:0]    ovf_evt;
   logic [NCH-1:0]    timing;

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic in_a_q, in_b_q, se_act_q;
      wire  ch_wr    = wr_en && ch_sel && (32'(ch_idx) == c);
      wire  clr_cond = clr_all | clr_mask[c];
      wire  clr_res  = clr_cond | run_start;
      wire  in_a     = exec_vld && in_range(exec_addr, a_lo_q[c], a_hi_q[c]);
      wire  in_b     = exec_vld && in_range(exec_addr, b_lo_q[c], b_hi_q[c]);
      wire  at_end   = exec_new && (exec_addr == a_hi_q[c]);
      wire  acc_hit  = bus_new && in_range(bus_q.addr, b_lo_q[c], b_hi_q[c]) &&
                       acc_match(acc_q[c], bus_q.kind) && in_a_q;
      wire  enter_b  = in_b && !in_b_q;
      // Start wins when one fetch lies in both ranges, so back-to-back passes time.
      wire  se_act_d = in_a ? 1'b1 : (in_b ? 1'b0 : se_act_q);

      // Frozen whenever the user program is not running.
      assign timing[c] = run_q && !ovf_q[c] &&
                         (((mode_q[c] == MODE_RANGE_TIME) && in_a_q) ||
                          ((mode_q[c] == MODE_START_END) && se_act_q));
      wire  cnt_inc  = run_q &&
                       (((mode_q[c] == MODE_RANGE_TIME) && at_end) ||
                        ((mode_q[c] == MODE_START_END) && enter_b) ||
                        ((mode_q[c] == MODE_ACCESS) && acc_hit) ||
                        ((mode_q[c] == MODE_CALLED) && in_b && in_a_q));

      wire [TIME_W:0] tsum = {1'b0, time_q[c]} + {{(TIME_W - 1){1'b0}}, step};
      assign ovf_evt[c] = timing[c] && tsum[TIME_W];

      always_ff @(posedge clock_i or posedge rst_i) begin
         if (rst_i) begin
            mode_q[c] <= MODE_OFF;
            acc_q[c]  <= ACC_ANY;
            a_lo_q[c] <= '0;
            a_hi_q[c] <= '0;
            b_lo_q[c] <= '0;
            b_hi_q[c] <= '0;
         end else if (ce_i) begin
            if (clr_cond) begin
               mode_q[c] <= MODE_OFF;
               acc_q[c]  <= ACC_ANY;
               a_lo_q[c] <= '0;
               a_hi_q[c] <= '0;
               b_lo_q[c] <= '0;
               b_hi_q[c] <= '0;
            end else if (ch_wr) begin
               if (ch_word == CH_CTRL) begin
                  mode_q[c] <= rpc_mode_t'(pwdata_i[CTRL_MODE_LSB +: 3]);
                  acc_q[c]  <= rpc_acc_t'(pwdata_i[CTRL_ACC_LSB +: 3]);
               end
               if (ch_word == CH_A_LO) a_lo_q[c] <= pwdata_i;
               if (ch_word == CH_A_HI) a_hi_q[c] <= pwdata_i;
               if (ch_word == CH_B_LO) b_lo_q[c] <= pwdata_i;
               if (ch_word == CH_B_HI) b_hi_q[c] <= pwdata_i;
            end
         end
      end

      always_ff @(posedge clock_i or posedge rst_i) begin
         if (rst_i) begin
            time_q[c] <= '0;
            cnt_q[c]  <= '0;
            ovf_q[c]  <= 1'b0;
            in_a_q    <= 1'b0;
            in_b_q    <= 1'b0;
            se_act_q  <= 1'b0;
         end else if (ce_i) begin
            if (clr_res) begin
               time_q[c] <= '0;
               cnt_q[c]  <= '0;
               ovf_q[c]  <= 1'b0;
               in_a_q    <= 1'b0;
               in_b_q    <= 1'b0;
               se_act_q  <= 1'b0;
            end else begin
               if (timing[c]) time_q[c] <= tsum[TIME_W-1:0];
               if (ovf_evt[c]) ovf_q[c] <= 1'b1;
               if (cnt_inc) cnt_q[c] <= cnt_q[c] + {{(CNT_W - 1){1'b0}}, 1'b1};
               if (exec_vld && run_q) begin
                  in_a_q   <= in_a;
                  in_b_q   <= in_b;
                  se_act_q <= se_act_d;
               end
            end
         end
      end
   end

   // Global registers and interrupt status.
   wire [IRQ_W-1:0] irq_evt = {run_stop, ovf_evt};
   wire [IRQ_W-1:0] irq_clr = (wr_en && paddr_i == REG_IRQ_CLR) ? pwdata_i[IRQ_W-1:0] : '0;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         det_pc_q   <= 1'b1;
         res_q      <= RES_160;
         irq_stat_q <= '0;
         irq_en_q   <= '0;
      end else if (ce_i) begin
         if (wr_en && paddr_i == REG_GCFG) begin
            det_pc_q <= pwdata_i[GCFG_DET_PC_BIT];
            res_q    <= rpc_res_t'(pwdata_i[GCFG_RES_LSB +: 2]);
         end
         if (wr_en && paddr_i == REG_IRQ_EN) irq_en_q <= pwdata_i[IRQ_W-1:0];
         // A new event in the clearing cycle survives the clear.
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      end
   end

   assign irq_o = |(irq_stat_q & irq_en_q);

   // Read multiplexer. An overflowed channel reads its time as zero with the flag set.
   wire [2:0]        ri  = ch_idx;
   wire [TIME_W-1:0] rt  = ovf_q[ri] ? '0 : time_q[ri];
   logic [DATA_W-1:0] rd_data;

   always_comb begin
      rd_data = ZERO_WORD;
      if (ch_sel) begin
         unique case (ch_word)
            CH_CTRL:    rd_data = DATA_W'({acc_q[ri], 1'b0, mode_q[ri]});
            CH_A_LO:    rd_data = a_lo_q[ri];
            CH_A_HI:    rd_data = a_hi_q[ri];
            CH_B_LO:    rd_data = b_lo_q[ri];
            CH_B_HI:    rd_data = b_hi_q[ri];
            CH_TIME_LO: rd_data = rt[DATA_W-1:0];
            CH_TIME_HI: rd_data = {ovf_q[ri], {TIME_HI_PAD{1'b0}}, rt[TIME_W-1:DATA_W]};
            CH_COUNT:   rd_data = cnt_q[ri];
            default:    rd_data = ZERO_WORD;
         endcase
      end else if (paddr_i == REG_GCFG) begin
         rd_data = DATA_W'({res_q, det_pc_q});
      end else if (paddr_i == REG_STATUS) begin
         rd_data = DATA_W'({timing, {(STAT_CH_LSB - 1){1'b0}}, run_q});
      end else if (paddr_i == REG_IRQ_STAT) begin
         rd_data = DATA_W'(irq_stat_q);
      end else if (paddr_i == REG_IRQ_EN) begin
         rd_data = DATA_W'(irq_en_q);
      end
   end

   // Read data is caught while psel is high, so pready waits for one captured edge.
   logic              cap_q;
   logic [DATA_W-1:0] prdata_q;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cap_q    <= 1'b0;
         prdata_q <= ZERO_WORD;
      end else if (ce_i) begin
         cap_q <= psel_i & ~(penable_i & pready_o);
         if (psel_i) prdata_q <= hit ? rd_data : ZERO_WORD;
      end
   end

   assign pready_o  = ce_i & (pwrite_i | cap_q);
   assign pslverr_o = psel_i & penable_i & pready_o & ~hit;
   assign prdata_o  = prdata_q;
endmodule : rpc_top
`default_nettype wire
